// File: rtl/emt_pkg.sv
// emt_pkg: register map, field layout and timing constants of the external memory timing engine
package emt_pkg;

  // bus address width; register indices sit at byte address index*4
  localparam int ADR_W = 10;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] IDX_TIMING = 8'hA1; // external_memory_timing_ctrl
  localparam logic [7:0] IDX_CONFIG = 8'hA3; // ext_mem_config
  localparam logic [7:0] IDX_PAGE = 8'hAF; // xram_page_register
  localparam logic [7:0] IDX_STATUS = 8'hB0; // engine status, read only

  // reset values
  localparam logic [7:0] TIMING_RST = 8'hFF;
  localparam logic [7:0] CONFIG_RST = 8'h03;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CONFIG_WMASK = 8'h3F; // bits 7-6 unused, read as zero

  // timing control field positions
  localparam int SETUP_HI = 7;
  localparam int SETUP_LO = 6;
  localparam int WIDTH_HI = 5;
  localparam int WIDTH_LO = 2;
  localparam int HOLD_HI = 1;
  localparam int HOLD_LO = 0;

  // configuration field positions
  localparam int CFG_PORT_BIT = 5;
  localparam int CFG_MUX_BIT = 4; // mux_mode_sel: 1 = separate pins
  localparam int CFG_MODE_HI = 3;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_ALE_HI = 1;
  localparam int CFG_ALE_LO = 0;

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SEP_BIT = 1;

  // memory modes in config bits 3-2
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOPAGE = 2'h1;
  localparam logic [1:0] MODE_SPLIT_PAGE = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // cycle counts
  localparam int CNT_W = 5;
  localparam int INSTR_CYCLES = 3; // instruction transfer overhead
  localparam int MIN_ACCESS_CYCLES = 4; // shortest off-chip access
  localparam logic [CNT_W-1:0] PREP_CYCLES = 5'h02; // address phase before setup
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [3:0] WIDTH_LINEAR_MAX = 4'h8;
  localparam logic [3:0] WIDTH_FULL_CODE = 4'hF;
  localparam logic [CNT_W-1:0] WIDTH_LINEAR_ADD = 5'h01;
  localparam logic [CNT_W-1:0] WIDTH_HALF_ADD = 5'h02; // half cycle rounded up
  localparam logic [CNT_W-1:0] WIDTH_FULL_CYCLES = 5'h10;

  // sequencer states
  typedef enum logic [2:0] {
    EMT_IDLE,
    EMT_PREP,
    EMT_ALE_HIGH,
    EMT_ALE_LOW,
    EMT_SETUP,
    EMT_STROBE,
    EMT_HOLD,
    EMT_FINISH
  } emt_state_t;

  // strobe width code to whole cycles; half cycles round up to the next cycle
  function automatic logic [CNT_W-1:0] emt_width_cycles(input logic [3:0] code);
    logic [CNT_W-1:0] c;
    c = {1'b0, code};
    if (code <= WIDTH_LINEAR_MAX)
      emt_width_cycles = c + WIDTH_LINEAR_ADD;
    else if (code == WIDTH_FULL_CODE)
      emt_width_cycles = WIDTH_FULL_CYCLES;
    else
      emt_width_cycles = c + WIDTH_HALF_ADD;
  endfunction : emt_width_cycles

endpackage : emt_pkg

// File: rtl/emt_pin_filter.sv
// emt_pin_filter: three-flop synchroniser with agreement filter for the shared data pins
`timescale 1ns/1ps
`default_nettype none
module emt_pin_filter (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [7:0] pin_i, // raw pin levels
  output logic [7:0] filt_o // filtered levels
);

  // one chain per pin bit; a change counts only once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      logic s1_reg; // first stage, read only by the second
      logic s2_reg; // second stage
      logic s3_reg; // third stage
      logic filt_reg; // accepted level

      // shift chain and agreement filter
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          filt_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= pin_i[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            filt_reg <= s3_reg;
        end
      end

      assign filt_o[b] = filt_reg;
    end
  endgenerate

endmodule : emt_pin_filter
`default_nettype wire

// File: rtl/emt_ext_mem_timing.sv
// emt_ext_mem_timing: external data memory timing engine with a Wishbone register port
//
// How it works
// - phase lengths counted from programmable timing fields
// - shortest non-multiplexed access takes four cycles
// - timing register resets to all ones
// - bits 7-6 add 0-3 setup cycles
// - bits 5-2 set read/write strobe width
// - bits 1-0 add 0-3 hold cycles
// - latch strobe high and low 1-4 cycles
// - write data leads strobe end 1-19 cycles
// - write data held 0-3 cycles after strobe
// - codes 101/110/111 select separate-pin sequencing
// - separate pins: 110 pages, 101/111 do not
// - codes 001/010/011 select multiplexed sequencing with latch
// - multiplexed: 010 pages, 001/011 do not
// - latch strobe high while low address shown
// - multiplex select 0 shares pins, 1 separates
// - paged short moves take page and index bytes
`timescale 1ns/1ps
`default_nettype none
module emt_ext_mem_timing (
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [emt_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic mov_req_i, // core external move request, one cycle
  input wire logic mov_we_i, // 1 = write
  input wire logic mov_short_i, // 1 = 8-bit indirect form
  input wire logic [15:0] mov_ptr_i, // 16-bit data pointer
  input wire logic [7:0] mov_index_i, // indirect index byte
  input wire logic [7:0] mov_wdata_i, // write byte
  output logic [7:0] mov_rdata_o, // read byte
  output logic mov_done_o, // access finished, one cycle
  output logic mov_busy_o, // access in progress
  output logic [7:0] addr_hi_o, // upper address pins
  output logic addr_hi_oe_n_o, // upper address enable, low drives
  output logic [7:0] addr_lo_o, // lower address pins, separate mode
  output logic addr_lo_oe_n_o, // lower address enable, low drives
  output logic [7:0] ad_o, // data or shared address/data pins
  output logic ad_oe_n_o, // data pin enable, low drives
  input wire logic [7:0] ad_i, // data pin levels
  output logic ale_o, // address latch strobe
  output logic rd_n_o, // read strobe, active low
  output logic wr_n_o, // write strobe, active low
  output logic port_sel_o // selected pin group
);
  import emt_pkg::*;

  // register file
  logic [7:0] tmg_reg; // external_memory_timing_ctrl
  logic [7:0] cfg_reg; // ext_mem_config
  logic [7:0] page_reg; // xram_page_register
  logic ack_reg; // bus acknowledge
  logic [31:0] rdat_reg; // bus read data

  // sequencer
  emt_state_t state_reg; // current phase
  emt_state_t state_next; // next phase
  logic [CNT_W-1:0] cnt_reg; // cycles left in phase, minus one
  logic [CNT_W-1:0] cnt_next; // next count

  // access settings frozen at start so register writes cannot tear an access
  logic [7:0] tmg_lat; // timing settings
  logic sep_lat; // separate pins
  logic [1:0] mode_lat; // memory mode
  logic [1:0] ale_lat; // latch strobe width code
  logic we_lat; // write access
  logic short_lat; // 8-bit form
  logic [15:0] addr_lat; // effective address
  logic [7:0] wdata_lat; // write byte

  // pin and core output registers
  logic [7:0] addr_hi_reg; // upper address
  logic addr_hi_oe_n_reg; // upper enable
  logic [7:0] addr_lo_reg; // lower address
  logic addr_lo_oe_n_reg; // lower enable
  logic [7:0] ad_reg; // shared pins
  logic ad_oe_n_reg; // shared enable
  logic ale_reg; // latch strobe
  logic rd_n_reg; // read strobe
  logic wr_n_reg; // write strobe
  logic [7:0] rdata_reg; // captured read byte
  logic done_reg; // done pulse
  logic busy_reg; // busy level
  logic [7:0] ad_filt; // filtered data pins

  // phase decoding, used only by the pin enable logic
  function automatic logic phase_active(input emt_state_t s);
    phase_active = (s != EMT_IDLE) && (s != EMT_FINISH);
  endfunction : phase_active

  function automatic logic phase_data(input emt_state_t s);
    phase_data = (s == EMT_SETUP) || (s == EMT_STROBE) || (s == EMT_HOLD);
  endfunction : phase_data

  // bus decode
  wire [7:0] bus_idx = wb_adr_i[ADR_W-1:IDX_LSB]; // register index
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg; // new classic request
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0]; // low lane write
  wire hit_tmg = bus_idx == IDX_TIMING;
  wire hit_cfg = bus_idx == IDX_CONFIG;
  wire hit_page = bus_idx == IDX_PAGE;
  wire hit_stat = bus_idx == IDX_STATUS;
  wire [7:0] stat_val = {6'h00, sep_lat && busy_reg, busy_reg};
  // unmapped addresses answer with zero and ignore writes
  wire [7:0] rd_byte = hit_tmg ? tmg_reg :
                       hit_cfg ? (cfg_reg & CONFIG_WMASK) :
                       hit_page ? page_reg :
                       hit_stat ? stat_val : 8'h00;

  // access request decode
  wire start = mov_req_i && (state_reg == EMT_IDLE); // requests while busy are ignored
  wire [1:0] cfg_mode = cfg_reg[CFG_MODE_HI:CFG_MODE_LO];
  wire cfg_sep = cfg_reg[CFG_MUX_BIT];
  wire page_form = short_lat && (mode_lat == MODE_SPLIT_PAGE);
  wire hi_drive = !short_lat || (mode_lat == MODE_SPLIT_PAGE);
  wire [7:0] start_hi = mov_short_i ? page_reg : mov_ptr_i[15:8];
  wire [7:0] start_lo = mov_short_i ? mov_index_i : mov_ptr_i[7:0];
  wire [1:0] setup_f = tmg_lat[SETUP_HI:SETUP_LO];
  wire [3:0] width_f = tmg_lat[WIDTH_HI:WIDTH_LO];
  wire [1:0] hold_f = tmg_lat[HOLD_HI:HOLD_LO];
  wire [CNT_W-1:0] width_cyc = emt_width_cycles(width_f);
  wire phase_end = cnt_reg == {CNT_W{1'b0}};
  wire cap_read = (state_reg == EMT_STROBE) && phase_end && !we_lat;

  // register file and bus answer: one cycle to ack, write lands on the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmg_reg <= TIMING_RST;
      cfg_reg <= CONFIG_RST;
      page_reg <= PAGE_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req) rdat_reg <= {24'h00_0000, rd_byte};
      if (bus_wr && hit_tmg) tmg_reg <= wb_dat_i[7:0];
      if (bus_wr && hit_cfg) cfg_reg <= wb_dat_i[7:0] & CONFIG_WMASK;
      if (bus_wr && hit_page) page_reg <= wb_dat_i[7:0];
    end
  end

  // phase sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      EMT_IDLE:
      begin
        if (start && (cfg_mode == MODE_INTERNAL))
          state_next = EMT_FINISH; // on-chip only: no pin activity
        else if (start && cfg_sep)
          state_next = EMT_PREP;
        else if (start)
          state_next = EMT_ALE_HIGH;
      end
      EMT_PREP, EMT_ALE_LOW:
        if (phase_end) state_next = (setup_f != 2'h0) ? EMT_SETUP : EMT_STROBE;
      EMT_ALE_HIGH:
        if (phase_end) state_next = EMT_ALE_LOW;
      EMT_SETUP:
        if (phase_end) state_next = EMT_STROBE;
      EMT_STROBE:
        if (phase_end) state_next = (hold_f != 2'h0) ? EMT_HOLD : EMT_FINISH;
      EMT_HOLD:
        if (phase_end) state_next = EMT_FINISH;
      EMT_FINISH: state_next = EMT_IDLE;
      default: state_next = EMT_IDLE;
    endcase
  end

  // phase length loaded on entry, counted down otherwise
  always_comb
  begin
    cnt_next = cnt_reg - CNT_ONE;
    if (state_next != state_reg)
    begin
      case (state_next)
        EMT_PREP: cnt_next = PREP_CYCLES - CNT_ONE;
        EMT_ALE_HIGH: cnt_next = {3'h0, ale_lat};
        EMT_ALE_LOW: cnt_next = {3'h0, ale_lat};
        EMT_SETUP: cnt_next = {3'h0, setup_f} - CNT_ONE;
        EMT_STROBE: cnt_next = width_cyc - CNT_ONE;
        EMT_HOLD: cnt_next = {3'h0, hold_f} - CNT_ONE;
        default: cnt_next = {CNT_W{1'b0}};
      endcase
    end
  end

  // sequencer state; ale width is taken from the config before latching
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= EMT_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (start && !cfg_sep) ? {3'h0, cfg_reg[CFG_ALE_HI:CFG_ALE_LO]} : cnt_next;
    end
  end

  // freeze the settings and operands of an access
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmg_lat <= TIMING_RST;
      sep_lat <= 1'b0;
      mode_lat <= MODE_INTERNAL;
      ale_lat <= 2'h0;
      we_lat <= 1'b0;
      short_lat <= 1'b0;
      addr_lat <= 16'h0000;
      wdata_lat <= 8'h00;
    end
    else if (start)
    begin
      tmg_lat <= tmg_reg;
      sep_lat <= cfg_sep;
      mode_lat <= cfg_mode;
      ale_lat <= cfg_reg[CFG_ALE_HI:CFG_ALE_LO];
      we_lat <= mov_we_i;
      short_lat <= mov_short_i;
      addr_lat <= {start_hi, start_lo};
      wdata_lat <= mov_wdata_i;
    end
  end

  // pin values; pins follow the phase one cycle later, so lengths are kept
  wire act = phase_active(state_reg);
  wire strobe_on = state_reg == EMT_STROBE;
  wire mux_addr = !sep_lat && ((state_reg == EMT_ALE_HIGH) || (state_reg == EMT_ALE_LOW));
  wire drive_wdata = we_lat && phase_data(state_reg);
  wire [7:0] ad_val = mux_addr ? addr_lat[7:0] : wdata_lat;

  // pin and core output registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_hi_reg <= 8'h00;
      addr_hi_oe_n_reg <= 1'b1;
      addr_lo_reg <= 8'h00;
      addr_lo_oe_n_reg <= 1'b1;
      ad_reg <= 8'h00;
      ad_oe_n_reg <= 1'b1;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      addr_hi_reg <= addr_lat[15:8];
      addr_hi_oe_n_reg <= !(act && hi_drive);
      addr_lo_reg <= addr_lat[7:0];
      addr_lo_oe_n_reg <= !(act && sep_lat);
      ad_reg <= ad_val;
      ad_oe_n_reg <= !(mux_addr || drive_wdata);
      ale_reg <= state_reg == EMT_ALE_HIGH;
      rd_n_reg <= !(strobe_on && !we_lat);
      wr_n_reg <= !(strobe_on && we_lat);
      if (cap_read)
        rdata_reg <= ad_filt;
      done_reg <= state_reg == EMT_FINISH;
      busy_reg <= state_next != EMT_IDLE;
    end
  end

  // data pin synchroniser; its latency is why read data must settle early
  emt_pin_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ad_i),
    .filt_o(ad_filt)
  );

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign mov_rdata_o = rdata_reg;
  assign mov_done_o = done_reg;
  assign mov_busy_o = busy_reg;
  assign addr_hi_o = addr_hi_reg;
  assign addr_hi_oe_n_o = addr_hi_oe_n_reg;
  assign addr_lo_o = addr_lo_reg;
  assign addr_lo_oe_n_o = addr_lo_oe_n_reg;
  assign ad_o = ad_reg;
  assign ad_oe_n_o = ad_oe_n_reg;
  assign ale_o = ale_reg;
  assign rd_n_o = rd_n_reg;
  assign wr_n_o = wr_n_reg;
  assign port_sel_o = cfg_reg[CFG_PORT_BIT];

  // checking helpers: strobe low length, latch high length, address-only length
  wire strobe_n = rd_n_o && wr_n_o;
  logic [CNT_W-1:0] strb_len_reg; // cycles strobe has been low
  logic [CNT_W-1:0] ale_len_reg; // cycles latch strobe has been high
  logic [CNT_W-1:0] side_len_reg; // cycles address valid with strobe high

  // helper counters read only by the checks below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strb_len_reg <= {CNT_W{1'b0}};
      ale_len_reg <= {CNT_W{1'b0}};
      side_len_reg <= {CNT_W{1'b0}};
    end
    else
    begin
      strb_len_reg <= strobe_n ? {CNT_W{1'b0}} : strb_len_reg + CNT_ONE;
      ale_len_reg <= ale_o ? ale_len_reg + CNT_ONE : {CNT_W{1'b0}};
      side_len_reg <= (strobe_n && !addr_lo_oe_n_o) ? side_len_reg + CNT_ONE : {CNT_W{1'b0}};
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_timing_a: assert property (disable iff (1'b0) rst_i |=> tmg_reg == TIMING_RST)
    else $error("timing register not all ones after reset");
  strobe_width_a: assert property ($rose(strobe_n) |-> strb_len_reg == width_cyc)
    else $error("strobe width differs from its setting");
  min_access_a: assert property ((start && cfg_mode != MODE_INTERNAL) |=>
    (!mov_done_o)[*4]) else $error("off-chip access shorter than four cycles");
  setup_len_a: assert property (($fell(strobe_n) && sep_lat) |->
    side_len_reg == PREP_CYCLES + {3'h0, setup_f}) else $error("address setup length wrong");
  hold_len_a: assert property (($rose(addr_lo_oe_n_o) && sep_lat) |->
    side_len_reg == {3'h0, hold_f}) else $error("address hold length wrong");
  ale_width_a: assert property ($fell(ale_o) |->
    ale_len_reg == {3'h0, ale_lat} + CNT_ONE) else $error("latch strobe high time wrong");
  ale_addr_a: assert property (ale_o |-> (!ad_oe_n_o && ad_o == addr_lat[7:0]))
    else $error("low address missing while latch strobe high");
  wdata_drive_a: assert property (!wr_n_o |-> (!ad_oe_n_o && ad_o == wdata_lat))
    else $error("write data not driven during write strobe");
  wdata_hold_a: assert property ($rose(wr_n_o) |-> ad_oe_n_o == (hold_f == 2'h0))
    else $error("write data hold disagrees with hold setting");
  sep_no_ale_a: assert property ((busy_reg && sep_lat) |->
    (!ale_o && $stable(ale_o))) else $error("latch strobe active with separate pins");
  page_addr_a: assert property ((page_form && !strobe_n) |->
    (!addr_hi_oe_n_o && addr_hi_o == addr_lat[15:8]))
    else $error("paged upper address not driven");
  nopage_hi_a: assert property ((short_lat && !page_form) |-> addr_hi_oe_n_o)
    else $error("upper address driven in a mode without page select");
  mux_ale_a: assert property ((start && !cfg_sep && cfg_mode != MODE_INTERNAL) |->
    ##2 ale_o) else $error("multiplexed access without latch phase");

endmodule : emt_ext_mem_timing
`default_nettype wire

// File: tb/emt_sram_model.sv
// emt_sram_model: external parallel memory behind an address latch
`timescale 1ns/1ps
`default_nettype none
module emt_sram_model (
  input wire logic clk_i, // system clock
  input wire logic [7:0] addr_hi_i, // upper address pins
  input wire logic addr_hi_oe_n_i, // upper address enable, low drives
  input wire logic [7:0] addr_lo_i, // lower address pins
  input wire logic addr_lo_oe_n_i, // lower address enable, low drives
  input wire logic [7:0] ad_i, // device level on shared pins
  input wire logic ad_oe_n_i, // device data enable, low drives
  input wire logic ale_i, // address latch strobe
  input wire logic rd_n_i, // read strobe
  input wire logic wr_n_i, // write strobe
  output logic [7:0] wire_o // resolved level of the shared pins
);
  logic [7:0] mem [0:65535]; // storage
  logic [7:0] lat_reg; // external address latch
  logic [7:0] last_reg = 8'h00; // last level seen on the pins
  logic [15:0] addr; // effective address
  // undriven upper pins read as zero; lower byte from pins or from the latch
  assign addr = {addr_hi_oe_n_i ? 8'h00 : addr_hi_i, addr_lo_oe_n_i ? lat_reg : addr_lo_i};
  // device wins, memory drives while read strobe low, else the lines drift
  assign wire_o = !ad_oe_n_i ? ad_i : (!rd_n_i ? mem[addr] : ~last_reg);
  // latch follows while strobe high, frozen once it falls
  always @(posedge clk_i)
  begin
    if (ale_i)
      lat_reg <= ad_i;
    if (!wr_n_i && !ad_oe_n_i)
      mem[addr] <= ad_i;
    last_reg <= wire_o;
  end
endmodule : emt_sram_model
`default_nettype wire

// File: tb/testbench.sv
// testbench: directed tests of the external memory timing engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import emt_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
  logic [ADR_W-1:0] adr = '0; // bus address
  logic [31:0] wdat = '0, wb_dat_o; // bus data
  logic wb_ack_o; // bus answer
  logic mov_req = 1'b0, mov_we = 1'b0, mov_short = 1'b0; // move request
  logic [15:0] mov_ptr = '0; // move pointer
  logic [7:0] mov_idx = '0, mov_wd = '0, mov_rdata_o; // move data
  logic mov_done_o, mov_busy_o, port_sel_o, ale_o, rd_n_o, wr_n_o; // status and strobes
  logic [7:0] addr_hi_o, addr_lo_o, ad_o, pins; // pin levels
  logic addr_hi_oe_n_o, addr_lo_oe_n_o, ad_oe_n_o; // pin enables
  int num_errors = 0, compares = 0; // verdict counters
  int n_stb, n_ale, n_dat, n_hi, n_bsy; // pin activity per access

  always #10 clk_i = ~clk_i;

  emt_ext_mem_timing u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mov_req_i(mov_req), .mov_we_i(mov_we), .mov_short_i(mov_short),
    .mov_ptr_i(mov_ptr), .mov_index_i(mov_idx), .mov_wdata_i(mov_wd),
    .mov_rdata_o(mov_rdata_o), .mov_done_o(mov_done_o), .mov_busy_o(mov_busy_o),
    .addr_hi_o(addr_hi_o), .addr_hi_oe_n_o(addr_hi_oe_n_o), .addr_lo_o(addr_lo_o),
    .addr_lo_oe_n_o(addr_lo_oe_n_o), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o), .ad_i(pins),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .port_sel_o(port_sel_o));

  emt_sram_model u_mem (.clk_i(clk_i), .addr_hi_i(addr_hi_o), .addr_hi_oe_n_i(addr_hi_oe_n_o),
    .addr_lo_i(addr_lo_o), .addr_lo_oe_n_i(addr_lo_oe_n_o), .ad_i(ad_o),
    .ad_oe_n_i(ad_oe_n_o), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .wire_o(pins));

  // counters restart on the request cycle, which never has pin activity
  always @(posedge clk_i)
  begin
    n_stb <= mov_req ? 0 : n_stb + int'(!rd_n_o || !wr_n_o);
    n_ale <= mov_req ? 0 : n_ale + int'(ale_o);
    n_dat <= mov_req ? 0 : n_dat + int'(!ad_oe_n_o);
    n_hi <= mov_req ? 0 : n_hi + int'(!addr_hi_oe_n_o);
    n_bsy <= mov_req ? 0 : n_bsy + int'(mov_busy_o);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  // one classic cycle; held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    check(n, 2, "bus ack latency");
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, exp, "register read");
  endtask : rd

  // one request pulse; lat counts edges from the taking edge to the done cycle
  task automatic mov(input logic w, input logic s, input logic [15:0] p, input logic [7:0] d,
                     output int lat);
    mov_req <= 1'b1;
    mov_we <= w;
    mov_short <= s;
    mov_ptr <= p;
    mov_idx <= p[7:0];
    mov_wd <= d;
    lat = -1;
    do
    begin
      @(posedge clk_i);
      mov_req <= 1'b0;
      lat++;
    end
    while (mov_done_o !== 1'b1 && lat < 200);
    @(posedge clk_i);
  endtask : mov

  // strobe cycles per width code; half cycles round up to whole ones
  function automatic int wcyc(input logic [3:0] c);
    return (c <= 4'h8) ? c + 1 : ((c == 4'hF) ? 16 : c + 2);
  endfunction : wcyc

  task automatic t_reset;
    rd(IDX_TIMING, 8'hFF);
    rd(IDX_CONFIG, 8'h03);
    rd(IDX_PAGE, 8'h00);
    rd(IDX_STATUS, 8'h00);
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h00);
    wr(IDX_CONFIG, 8'h23);
    check(port_sel_o, 1, "port select");
    wr(IDX_CONFIG, 8'hC3);
    rd(IDX_CONFIG, 8'h03);
    check(port_sel_o, 0, "port select clear");
    $display("test reset done");
  endtask : t_reset

  task automatic t_min;
    int lat;
    wr(IDX_CONFIG, 8'h1C);
    wr(IDX_TIMING, 8'h00);
    mov(1'b1, 1'b0, 16'h1234, 8'hA5, lat);
    check(lat, 5, "shortest access");
    check(n_stb, 1, "shortest strobe");
    check(n_bsy, 4, "shortest busy span");
    check(u_mem.mem[16'h1234], 8'hA5, "shortest write");
    wr(IDX_CONFIG, 8'h10);
    mov(1'b1, 1'b0, 16'h1234, 8'h11, lat);
    check(lat, 2, "internal access");
    check(n_stb, 0, "internal no strobe");
    check(n_bsy, 1, "internal busy span");
    $display("test minimum done");
  endtask : t_min

  task automatic t_sep;
    // read strobes of at least seven cycles cover the data pin synchroniser latency
    logic [7:0] tv [4] = '{8'hFF, 8'h65, 8'h22, 8'h9C};
    logic [7:0] cf [4] = '{8'h1C, 8'h14, 8'h18, 8'h1C};
    logic [7:0] d;
    int lat, t;
    foreach (tv[i])
    begin
      d = ~tv[i];
      t = tv[i][7:6] + wcyc(tv[i][5:2]) + tv[i][1:0];
      wr(IDX_CONFIG, cf[i]);
      wr(IDX_TIMING, tv[i]);
      mov(1'b1, 1'b0, {8'hE0, tv[i]}, d, lat);
      check(lat, 4 + t, "separate write time");
      check(n_stb, wcyc(tv[i][5:2]), "strobe width");
      check(n_dat, t, "write data window");
      check(n_hi, 2 + t, "address window");
      check(n_ale, 0, "no latch strobe");
      mov(1'b0, 1'b0, {8'hE0, tv[i]}, 8'h00, lat);
      check(lat, 4 + t, "separate read time");
      check(mov_rdata_o, d, "separate read data");
      check(n_dat, 0, "read leaves pins");
    end
    $display("test separate done");
  endtask : t_sep

  task automatic t_mux;
    logic [15:0] p;
    int lat;
    wr(IDX_TIMING, 8'h1C);
    for (int a = 0; a < 4; a++)
    begin
      p = 16'hC130 + a;
      wr(IDX_CONFIG, {4'h0, 2'(a % 3 + 1), 2'(a)});
      mov(1'b1, 1'b0, p, p[7:0] ^ 8'h5F, lat);
      check(lat, 2 * a + 12, "mux write time");
      check(n_ale, a + 1, "latch strobe high");
      check(u_mem.mem[p], p[7:0] ^ 8'h5F, "mux write");
      mov(1'b0, 1'b0, p, 8'h00, lat);
      check(mov_rdata_o, p[7:0] ^ 8'h5F, "mux read");
    end
    $display("test multiplexed done");
  endtask : t_mux

  task automatic t_page;
    int lat;
    wr(IDX_PAGE, 8'h5A);
    wr(IDX_CONFIG, 8'h18);
    mov(1'b1, 1'b1, 16'h0033, 8'h6C, lat);
    check(u_mem.mem[16'h5A33], 8'h6C, "paged write");
    check(n_hi > 0, 1, "page drives upper");
    wr(IDX_CONFIG, 8'h14);
    mov(1'b1, 1'b1, 16'h5A77, 8'h29, lat);
    check(n_hi, 0, "no page upper idle");
    check(u_mem.mem[16'h0077], 8'h29, "unpaged write");
    wr(IDX_CONFIG, 8'h08);
    mov(1'b0, 1'b1, 16'h0033, 8'h00, lat);
    check(mov_rdata_o, 8'h6C, "mux paged read");
    wr(IDX_CONFIG, 8'h0C);
    mov(1'b0, 1'b1, 16'h5A77, 8'h00, lat);
    check(n_hi, 0, "mux unpaged upper idle");
    check(mov_rdata_o, 8'h29, "mux unpaged read");
    $display("test page done");
  endtask : t_page

  task automatic final_report;
    $display("TB: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // the tests need well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    final_report;
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_min;
    t_sep;
    t_mux;
    t_page;
    final_report;
  end
endmodule : testbench
`default_nettype wire
